/* rtl/fractional_pll_lock_control.v */
`include "pll_lock_defines.vh"
`default_nettype none
// ----------------------------------------
// lock supervision and output gating
// ----------------------------------------
module fractional_pll_lock_control #(
  parameter integer LT10_CYC  = `LT_10MS_US * `CLK_MHZ,
  parameter integer LT11_CYC  = `LT_11MS_US * `CLK_MHZ,
  parameter integer LTDEF_CYC = `LT_DEF_US * `CLK_MHZ
) (
  // clock, reset, enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // control bits
  input  wire        pll_enable,
  input  wire        lock_gate_bypass,
  input  wire [2:0]  lock_timeout_sel,
  input  wire [15:0] pll_ratio_in,
  input  wire        pll_ratio_wr,
  // flag clears, one-cycle pulses
  input  wire        clr_lock_rise,
  input  wire        clr_lock_fall,
  input  wire        clr_ratio_load,
  // raw lock detector from the loop (async)
  input  wire        lock_raw,
  input  wire        pll_clk_tick,
  // status
  output reg         lock_status_ff,
  output reg         clock_ready_flag_ff,
  output reg         lock_timeout_ff,
  output reg         ratio_load_status_ff,
  output reg         lock_rise_flag_ff,
  output reg         lock_fall_flag_ff,
  output reg         ratio_load_done_ff,
  output reg  [15:0] pll_ratio_reg_ff,
  // gated output toward the clock generators
  output reg         pll_out_en_ff,
  output reg         pll_clk_out_ff
);
  localparam [2:0] ST_OFF  = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg       lock_s1_ff;
  reg       lock_s2_ff;
  reg       tick_s1_ff;
  reg       tick_s2_ff;
  reg [2:0] rdy_cnt_ff;
  wire      tmo;
  wire      lock_up;
  wire      lock_dn;
  wire      gate_open;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // detector is async; two stages before anything looks at it
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
    end
    else if (ce)
    begin
      lock_s1_ff <= lock_raw;
      lock_s2_ff <= lock_s1_ff;
      tick_s1_ff <= pll_clk_tick;
      tick_s2_ff <= tick_s1_ff;
    end
  end

  // edges of lock status; a drop can come any time [RL1]
  assign lock_up = lock_s2_ff & ~lock_status_ff & (state_ff != ST_OFF);
  assign lock_dn = lock_status_ff & ~(lock_s2_ff & (state_ff != ST_OFF)); // [RL1]

  lock_timer #(
    .T10_CYC  (LT10_CYC),
    .T11_CYC  (LT11_CYC),
    .TDEF_CYC (LTDEF_CYC)
  ) u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .run        (state_ff == ST_WAIT),
    .restart    (1'b0),
    .sel        (lock_timeout_sel),
    .expired_ff (tmo)
  );

  // ----------------------------------------
  // enable state machine
  // ----------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF:  if (pll_enable) nxt_state = ST_WAIT;
      ST_WAIT: if (!pll_enable) nxt_state = ST_OFF;
               else if (lock_status_ff || tmo) nxt_state = ST_RUN;
      ST_RUN:  if (!pll_enable) nxt_state = ST_OFF;
      default: nxt_state = ST_OFF;
    endcase
  end

  // gating: bypass ignores lock, otherwise lock required [RL3] [RL4]
  assign gate_open = (state_ff == ST_RUN) && (lock_gate_bypass || lock_s2_ff);

  // ----------------------------------------
  // state and lock status
  // ----------------------------------------
  // status forced low when off, so enabling never shows a stale lock
  // time-out result registered again so every output is a flip-flop
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff        <= ST_OFF;
      lock_status_ff  <= 1'b0;
      lock_timeout_ff <= 1'b0;
    end
    else if (ce)
    begin
      state_ff        <= nxt_state;
      lock_status_ff  <= lock_s2_ff & (state_ff != ST_OFF); // false unlocks still shown [RL4]
      lock_timeout_ff <= tmo;
    end
  end

  // ----------------------------------------
  // clock ready
  // ----------------------------------------
  // short settle once running; counter saturates so ready stays up
  // ready drops as soon as the loop leaves run
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdy_cnt_ff          <= 3'h0;
      clock_ready_flag_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (state_ff != ST_RUN)
        rdy_cnt_ff <= 3'h0;
      else if (rdy_cnt_ff != `READY_DLY_CYC)
        rdy_cnt_ff <= rdy_cnt_ff + 3'h1;
      clock_ready_flag_ff <= (state_ff == ST_RUN) && (rdy_cnt_ff == `READY_DLY_CYC);
    end
  end

  // ----------------------------------------
  // lock event flags
  // ----------------------------------------
  // sticky flags, set beats clear so no edge is lost to a late clear [RL10]
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      lock_rise_flag_ff <= 1'b0;
      lock_fall_flag_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (lock_up || lock_dn)
        lock_rise_flag_ff <= 1'b1; // drop also sets rise [RL2] [RL10]
      else if (clr_lock_rise)
        lock_rise_flag_ff <= 1'b0;
      if (lock_dn)
        lock_fall_flag_ff <= 1'b1; // [RL2] [RL10]
      else if (clr_lock_fall)
        lock_fall_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // ratio load
  // ----------------------------------------
  // applied at once; while running only the flag reports it [RL7]
  // a write while not running reports through the status bit instead
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pll_ratio_reg_ff     <= `RATIO_RESET;
      ratio_load_status_ff <= 1'b0;
      ratio_load_done_ff   <= 1'b0;
    end
    else if (ce)
    begin
      if (pll_ratio_wr)
      begin
        pll_ratio_reg_ff     <= pll_ratio_in; // [RL7]
        ratio_load_status_ff <= (state_ff != ST_RUN);
      end
      if (pll_ratio_wr && state_ff == ST_RUN)
        ratio_load_done_ff <= 1'b1; // [RL7] [RL8]
      else if (clr_ratio_load)
        ratio_load_done_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // output gating
  // ----------------------------------------
  // output halts during unlock unless bypassed, and resumes unaided [RL2] [RL5]
  // the tick is sampled, so the gated clock is at most half the system clock
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pll_out_en_ff  <= 1'b0;
      pll_clk_out_ff <= 1'b0;
    end
    else if (ce)
    begin
      pll_out_en_ff  <= gate_open;
      pll_clk_out_ff <= gate_open & tick_s2_ff; // [RL3] [RL5]
    end
  end
endmodule
`default_nettype wire

/* rtl/lock_timer.v */
`include "pll_lock_defines.vh"
`default_nettype none
// ----------------------------------------
// lock time-out counter
// ----------------------------------------
module lock_timer #(
  parameter integer T10_CYC = 500000,
  parameter integer T11_CYC = 550000,
  parameter integer TDEF_CYC = 400000
) (
  // clock and control
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        run,
  input  wire        restart,
  input  wire [2:0]  sel,
  // status
  output reg         expired_ff
);
  reg [23:0] cnt_ff;
  reg [23:0] limit;

  // decode of time-out field
  always @*
  begin
    case (sel)
      `LT_CODE_10MS_A, `LT_CODE_10MS_B: limit = T10_CYC[23:0]; // [RL6]
      `LT_CODE_11MS_A, `LT_CODE_11MS_B: limit = T11_CYC[23:0]; // [RL6]
      default:                          limit = TDEF_CYC[23:0];
    endcase
  end

  // count while waiting for lock; clears on restart
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_ff     <= 24'h000000;
      expired_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (!run || restart)
      begin
        cnt_ff     <= 24'h000000;
        expired_ff <= 1'b0;
      end
      else if (cnt_ff >= limit)
        expired_ff <= 1'b1;
      else
        cnt_ff <= cnt_ff + 24'h000001;
    end
  end
endmodule
`default_nettype wire

/* rtl/pll_lock_defines.vh */
// Operation
// [RL1] lock status may drop spuriously while running; never assume it stays set
// [RL2] on lock drop set rise and fall flags; mask output when gating active
// [RL3] lock gate bypass stops lock status from gating the output clock
// [RL4] with bypass, false unlocks still reported but output clock keeps running
// [RL5] spurious unlock with gating halts output, resumes alone afterwards
// [RL6] time-out codes 4,5 give 10 ms; codes 6,7 give 11 ms
// [RL7] on-the-fly ratio change applies ratio, sets flag, status bit stays clear
// [RL8] software watches the ratio-load flag, not the status bit
// [RL9] bring-up: bypass, enable, wait clock ready, then select as source
// [RL10] rise flag on lock rise, fall flag on lock fall; sticky until cleared
`ifndef PLL_LOCK_DEFINES_VH
`define PLL_LOCK_DEFINES_VH
`define LT_CODE_10MS_A  3'h4
`define LT_CODE_10MS_B  3'h5
`define LT_CODE_11MS_A  3'h6
`define LT_CODE_11MS_B  3'h7
`define LT_10MS_US      32'h00002710
`define LT_11MS_US      32'h00002AF8
`define LT_DEF_US       32'h00001F40
`define CLK_MHZ         32'h00000032
`define RATIO_RESET     16'h0000
`define READY_DLY_CYC   3'h4
`endif

/* tb/fractional_pll_lock_control_test.sv */
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module fractional_pll_lock_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, ce = 1, pll_enable = 0, lock_gate_bypass = 0, pll_ratio_wr = 0;
  logic clr_lock_rise = 0, clr_lock_fall = 0, clr_ratio_load = 0, drop = 0;
  logic [2:0] lock_timeout_sel = 3'h4;
  logic [15:0] pll_ratio_in = 16'h0000, r = 16'h0000;
  wire logic lock_raw, pll_clk_tick, lock_status_ff, clock_ready_flag_ff, lock_timeout_ff;
  wire logic ratio_load_status_ff, lock_rise_flag_ff, lock_fall_flag_ff, ratio_load_done_ff;
  wire logic pll_out_en_ff, pll_clk_out_ff;
  wire logic [15:0] pll_ratio_reg_ff;
  int seed = 98, miscompares = 0, tests_run = 0, n[8];
  logic [21:0] q[$];
  // short counts keep the time-out runs brief
  fractional_pll_lock_control #(.LT10_CYC(20), .LT11_CYC(22), .LTDEF_CYC(16)) i_dut (.*);
  loop_model i_loop (.*);
  always #10 clk = ~clk;
  // expected notes are taken off at the settled half of the cycle
  always @(negedge clk)
    while (q.size())
      chk({lock_status_ff, lock_rise_flag_ff, lock_fall_flag_ff, pll_out_en_ff,
        ratio_load_done_ff, ratio_load_status_ff, pll_ratio_reg_ff}, q.pop_front());
  task chk(input logic [21:0] s, input logic [21:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH outputs exp %h seen %h", e, s);
    end
  endtask
  task note(input logic [5:0] f);
    q.push_back({f, r});
  endtask
  task step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task clr;
    @(posedge clk) {clr_lock_rise, clr_lock_fall, clr_ratio_load} <= 3'h7;
    @(posedge clk) {clr_lock_rise, clr_lock_fall, clr_ratio_load} <= 3'h0;
    step(1);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    step(3000);
    miscompares++;
    test_done();
  end
  // main sequence
  initial
  begin
    step(4);
    rst_n <= 1;
    lock_gate_bypass <= 1;
    step(1);
    pll_enable <= 1;
    repeat (200) if (clock_ready_flag_ff !== 1'b1) @(posedge clk);
    chk(22'(clock_ready_flag_ff), 22'h000001);
    lock_gate_bypass <= 0;
    clr();
    note(6'h24);
    drop <= 1;
    step(5);
    note(6'h18);
    drop <= 0;
    step(8);
    note(6'h3C);
    $display("test gated unlock done");
    clr();
    lock_gate_bypass <= 1;
    drop <= 1;
    step(5);
    note(6'h1C);
    drop <= 0;
    step(8);
    clr();
    $display("test bypass unlock done");
    // two ratio loads while running, one idle cycle between them
    repeat (2)
    begin
      @(posedge clk) r = 16'($random(seed));
      pll_ratio_in <= r;
      pll_ratio_wr <= 1;
      @(posedge clk) pll_ratio_wr <= 0;
      note(6'h26);
    end
    $display("test ratio done");
    drop <= 1;
    // lock never arrives; count cycles to the time-out per code
    for (int c = 4; c < 8; c++)
    begin
      @(posedge clk) pll_enable <= 0;
      step(3);
      lock_timeout_sel <= 3'(c);
      pll_enable <= 1;
      n[c] = 0;
      while (lock_timeout_ff !== 1'b1 && n[c] < 99)
      begin
        @(negedge clk);
        n[c]++;
      end
      chk(22'(n[c] - n[4]), (c > 5) ? 22'h000002 : 22'h000000);
    end
    // 20-cycle limit plus enable, count-end and output register latency
    chk(22'(n[4]), 22'h000018);
    $display("test time-out done");
    test_done();
  end
endmodule
bind fractional_pll_lock_control pll_lock_assertions i_chk (.*);
`default_nettype wire

/* tb/loop_model.sv */
`default_nettype none
// ----------------------------------------
// loop lock source
// ----------------------------------------
module loop_model (
  input  wire logic clk,
  input  wire logic pll_enable,
  input  wire logic drop,
  output var  logic lock_raw,
  output var  logic pll_clk_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  // tick stands still when disabled; drop forces a false unlock
  always @(posedge clk)
  begin
    pll_clk_tick <= pll_enable & ~pll_clk_tick;
    lock_raw <= pll_enable & ~drop;
  end
endmodule
`default_nettype wire

/* tb/pll_lock_assertions.sv */
`default_nettype none
// ----------------------------------------
// lock supervision checker
// ----------------------------------------
module pll_lock_assertions (
  // inputs
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        lock_gate_bypass,
  input wire logic        pll_ratio_wr,
  input wire logic [15:0] pll_ratio_in,
  input wire logic        clr_lock_fall,
  // outputs
  input wire logic        lock_status_ff,
  input wire logic        clock_ready_flag_ff,
  input wire logic        ratio_load_status_ff,
  input wire logic        lock_rise_flag_ff,
  input wire logic        lock_fall_flag_ff,
  input wire logic        ratio_load_done_ff,
  input wire logic [15:0] pll_ratio_reg_ff,
  input wire logic        pll_out_en_ff,
  input wire logic        pll_clk_out_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // flags and gate against lock edges, ratio load, output clock
  drop_flags_a: assert property (
    $fell(lock_status_ff) |-> lock_rise_flag_ff && lock_fall_flag_ff) else $error("drop flags");
  rise_flag_a: assert property (
    $rose(lock_status_ff) |-> lock_rise_flag_ff) else $error("rise flag");
  gate_shut_a: assert property (
    $fell(lock_status_ff) && !$past(lock_gate_bypass) |-> !pll_out_en_ff)
    else $error("gate open");
  bypass_run_a: assert property (
    $fell(lock_status_ff) && $past(lock_gate_bypass) && $past(pll_out_en_ff)
    && clock_ready_flag_ff |-> pll_out_en_ff)
    else $error("bypass gated");
  gate_back_a: assert property (
    $rose(lock_status_ff) && clock_ready_flag_ff |-> ##[0:2] pll_out_en_ff)
    else $error("no resume");
  fall_stick_a: assert property (
    lock_fall_flag_ff && !clr_lock_fall |=> lock_fall_flag_ff) else $error("fall lost");
  ratio_load_a: assert property (
    pll_ratio_wr && clock_ready_flag_ff |=> ratio_load_done_ff && !$rose(ratio_load_status_ff)
    && pll_ratio_reg_ff == $past(pll_ratio_in)) else $error("ratio load");
  mask_low_a: assert property (
    !pll_out_en_ff && !$past(pll_out_en_ff) |-> !pll_clk_out_ff) else $error("clock leak");
  clk_runs_a: assert property (
    pll_out_en_ff && $past(pll_out_en_ff) |-> pll_clk_out_ff || $past(pll_clk_out_ff))
    else $error("clock stuck");
endmodule
`default_nettype wire
